// *** rtl/ohp_defs.vh ***
`ifndef OHP_DEFS_VH
`define OHP_DEFS_VH

// ==========================================================
// Operation select codes
`define OHP_OP_DECODE 2'h0
`define OHP_OP_ENCODE 2'h1
`define OHP_OP_SEGMENT 2'h2

// ==========================================================
// Control word and placement selector fields
`define OHP_MODE_HI 15
`define OHP_MODE_LO 12
`define OHP_HALF_HI 11
`define OHP_HALF_LO 8
`define OHP_CNT_HI 7
`define OHP_CNT_LO 4
`define OHP_FIRST_HI 3
`define OHP_FIRST_LO 0
`define OHP_MODE_NIBBLE 4'h0
`define OHP_MODE_BYTE 4'h1
`define OHP_NIB_FIELD_MAX 4'h3
`define OHP_BYTE_FIELD_MAX 4'h1
`define OHP_HALF_FIELD_MAX 4'h1

// ==========================================================
// Word counts and constants
`define OHP_GROUP_LAST 4'hf
`define OHP_ZERO_WORD 16'h0000
`define OHP_ONE_WORD 16'h0001
`define OHP_NIB_MASK 16'h000f
`define OHP_BYTE_MASK 16'h00ff
`define OHP_BCD_DIGIT_MAX 4'h9

// ==========================================================
// Seven-segment patterns, segment a in bit 0, bit 7 clear
`define OHP_SEG_0 8'h3f
`define OHP_SEG_1 8'h06
`define OHP_SEG_2 8'h5b
`define OHP_SEG_3 8'h4f
`define OHP_SEG_4 8'h66
`define OHP_SEG_5 8'h6d
`define OHP_SEG_6 8'h7d
`define OHP_SEG_7 8'h27
`define OHP_SEG_8 8'h7f
`define OHP_SEG_9 8'h6f
`define OHP_SEG_A 8'h77
`define OHP_SEG_B 8'h7c
`define OHP_SEG_C 8'h39
`define OHP_SEG_D 8'h5e
`define OHP_SEG_E 8'h79
`define OHP_SEG_F 8'h71

`endif

// *** rtl/ohp_prio16.v ***
`include "ohp_defs.vh"

// ==========================================================
// Highest set bit of a 16-bit word
module ohp_prio16 (
  input wire [15:0] word_in, // Word to scan
  output reg [3:0] index_out, // Bit number of highest set bit
  output wire any_out // High when any bit is set
);

  integer i;

  assign any_out = (word_in != `OHP_ZERO_WORD);

  // Scan upward so the highest set bit wins
  always @* begin
    index_out = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (word_in[i]) begin
        index_out = i[3:0];
      end
    end
  end

endmodule

// *** rtl/ohp_conv.v ***
// Operation
// - Control leftmost digit 0 selects 4-to-16 decode, 1 selects 8-to-256.
// - Execution condition off: nothing happens, destinations unchanged.
// - Each source digit sets one bit of its own result word, clears others.
// - Decode up to four digits from the first digit, wrapping past digit 3.
// - Byte decode sets one bit in a 16-word group, clears other 255.
// - Control fields within 0..3 in digit mode, 0..1 in byte mode.
// - Byte index 0 is the source low byte, 1 the high byte.
// - Decoder faults on bad control word or result words crossing area.
// - Control 0001 decodes a single digit taken from source digit 1.
// - Digit encode writes highest set bit number into chosen result digit.
// - Encode up to four source words into result digits, wrapping past 3.
// - Byte encode finds highest bit of 16 words, writes index as byte.
// - Encode byte index 0 is result low byte, 1 the high byte.
// - Control 0001 encodes one word into result digit 1.
// - Encoder faults on all-zero source, bad control, or area crossing.
// - Indirect pointer not BCD or above the pointer limit ptr_max_in raises the fault.
// - Segment op turns each chosen digit into an 8-bit segment pattern.
// - Selector gives first digit, count and first half; digits wrap.
// - Segment destinations must stay in one area, selector legal, else fault.
// - Segments a..g on bits 0..6, bit 7 always clear.
`include "ohp_defs.vh"

module ohp_conv (
  input wire sys_clk_in, // 40 MHz clock
  input wire resetn_in, // Asynchronous reset, active low
  input wire start_in, // One-cycle request pulse
  input wire exec_cond_in, // Execution condition
  input wire [1:0] op_in, // Operation select
  input wire [15:0] ctrl_in, // Control word or placement selector
  input wire [15:0] src_addr_in, // First source word address
  input wire [15:0] dst_addr_in, // First destination word address
  input wire [15:0] area_lo_in, // First address of the data area
  input wire [15:0] area_hi_in, // Last address of the data area
  input wire indirect_in, // Operand came through a pointer word
  input wire [15:0] ptr_word_in, // Pointer word contents
  input wire [15:0] ptr_max_in, // Highest legal pointer value, BCD
  input wire [15:0] mem_rdata_in, // Read data, one cycle after read strobe
  output wire busy_out, // Operation in progress
  output reg done_out, // One-cycle completion pulse
  output reg fault_flag_out, // Error flag of last executed op
  output reg mem_rd_out, // Word read strobe
  output reg mem_wr_out, // Word write strobe
  output reg [15:0] mem_addr_out, // Word address
  output reg [15:0] mem_wdata_out // Write data
);

  // ==========================================================
  // States
  localparam ST_IDLE = 4'h0;
  localparam ST_RSRC = 4'h1;
  localparam ST_WSRC = 4'h2;
  localparam ST_CSRC = 4'h3;
  localparam ST_RDST = 4'h4;
  localparam ST_WDST = 4'h5;
  localparam ST_CDST = 4'h6;
  localparam ST_WR = 4'h7;
  localparam ST_DONE = 4'h8;

  reg [3:0] state;
  reg [1:0] op;
  reg byte_mode;
  reg [1:0] first;
  reg [1:0] cnt_m1;
  reg half;
  reg [15:0] src_base;
  reg [15:0] dst_base;
  reg [5:0] idx;
  reg [5:0] last;
  reg [15:0] src_word;
  reg [15:0] acc;
  reg [7:0] best;
  reg hit;
  reg err;

  // ==========================================================
  // Helpers
  function [3:0] nib;
    input [15:0] w;
    input [1:0] s;
    begin
      case (s)
        2'h0: nib = w[3:0];
        2'h1: nib = w[7:4];
        2'h2: nib = w[11:8];
        default: nib = w[15:12];
      endcase
    end
  endfunction

  function [7:0] seg;
    input [3:0] d;
    begin
      case (d)
        4'h0: seg = `OHP_SEG_0;
        4'h1: seg = `OHP_SEG_1;
        4'h2: seg = `OHP_SEG_2;
        4'h3: seg = `OHP_SEG_3;
        4'h4: seg = `OHP_SEG_4;
        4'h5: seg = `OHP_SEG_5;
        4'h6: seg = `OHP_SEG_6;
        4'h7: seg = `OHP_SEG_7;
        4'h8: seg = `OHP_SEG_8;
        4'h9: seg = `OHP_SEG_9;
        4'ha: seg = `OHP_SEG_A;
        4'hb: seg = `OHP_SEG_B;
        4'hc: seg = `OHP_SEG_C;
        4'hd: seg = `OHP_SEG_D;
        4'he: seg = `OHP_SEG_E;
        default: seg = `OHP_SEG_F;
      endcase
    end
  endfunction

  function is_bcd;
    input [15:0] w;
    begin
      is_bcd = (w[3:0] <= `OHP_BCD_DIGIT_MAX) && (w[7:4] <= `OHP_BCD_DIGIT_MAX) &&
               (w[11:8] <= `OHP_BCD_DIGIT_MAX) && (w[15:12] <= `OHP_BCD_DIGIT_MAX);
    end
  endfunction

  // ==========================================================
  // Request checks, evaluated in the start cycle
  wire [3:0] c_mode = ctrl_in[`OHP_MODE_HI:`OHP_MODE_LO];
  wire [3:0] c_half = ctrl_in[`OHP_HALF_HI:`OHP_HALF_LO];
  wire [3:0] c_cnt = ctrl_in[`OHP_CNT_HI:`OHP_CNT_LO];
  wire [3:0] c_first = ctrl_in[`OHP_FIRST_HI:`OHP_FIRST_LO];
  wire c_byte = (c_mode == `OHP_MODE_BYTE);

  // Mode digit picks the field limits; anything else is undefined
  wire nib_ok = (c_mode == `OHP_MODE_NIBBLE) && (c_first <= `OHP_NIB_FIELD_MAX) &&
                (c_cnt <= `OHP_NIB_FIELD_MAX);
  wire byte_ok = c_byte && (c_first <= `OHP_BYTE_FIELD_MAX) &&
                 (c_cnt <= `OHP_BYTE_FIELD_MAX);
  wire seg_ok = (c_mode == `OHP_MODE_NIBBLE) && (c_first <= `OHP_NIB_FIELD_MAX) &&
                (c_cnt <= `OHP_NIB_FIELD_MAX) && (c_half <= `OHP_HALF_FIELD_MAX);

  reg ctrl_ok;
  reg [5:0] span_m1;
  reg [15:0] span_base;

  // Number of words the op touches, less one, and where they start
  always @* begin
    ctrl_ok = 1'b0;
    span_m1 = 6'h00;
    span_base = dst_addr_in;
    case (op_in)
      `OHP_OP_DECODE: begin
        ctrl_ok = nib_ok | byte_ok;
        span_m1 = c_byte ? {1'b0, c_cnt[0], `OHP_GROUP_LAST} : {4'h0, c_cnt[1:0]};
      end
      `OHP_OP_ENCODE: begin
        ctrl_ok = nib_ok | byte_ok;
        span_m1 = c_byte ? {1'b0, c_cnt[0], `OHP_GROUP_LAST} : {4'h0, c_cnt[1:0]};
        span_base = src_addr_in;
      end
      `OHP_OP_SEGMENT: begin
        ctrl_ok = seg_ok;
        span_m1 = ({5'h00, c_half[0]} + {4'h0, c_cnt[1:0]}) >> 1;
      end
      default: begin
        ctrl_ok = 1'b0;
      end
    endcase
  end

  // Span end may not pass the area end; encoder result word is checked too
  wire [16:0] span_end = {1'b0, span_base} + {11'h000, span_m1};
  wire span_ok = (span_base >= area_lo_in) && (span_end <= {1'b0, area_hi_in}) &&
                 ((op_in != `OHP_OP_ENCODE) ||
                  ((dst_addr_in >= area_lo_in) && (dst_addr_in <= area_hi_in)));
  wire ptr_ok = !indirect_in || (is_bcd(ptr_word_in) && (ptr_word_in <= ptr_max_in));
  wire start_err = !(ctrl_ok && span_ok && ptr_ok);

  // ==========================================================
  // Decoder word generation
  wire [1:0] dec_dig = first + idx[1:0];
  wire dec_sel = first[0] ^ idx[4];
  wire [7:0] dec_byte = dec_sel ? src_word[15:8] : src_word[7:0];
  wire [3:0] dec_nib = nib(src_word, dec_dig);
  wire [15:0] dec_word_nib = `OHP_ONE_WORD << dec_nib;
  wire [15:0] dec_word_byte = (idx[3:0] == dec_byte[7:4]) ?
                              (`OHP_ONE_WORD << dec_byte[3:0]) : `OHP_ZERO_WORD;
  wire [15:0] dec_word = byte_mode ? dec_word_byte : dec_word_nib;

  // ==========================================================
  // Encoder scan of the word just read
  wire [3:0] pe_index;
  wire pe_any;

  ohp_prio16 u_prio (
    .word_in(mem_rdata_in),
    .index_out(pe_index),
    .any_out(pe_any)
  );

  wire [1:0] enc_dig = first + idx[1:0];
  wire [3:0] enc_sh = {enc_dig, 2'b00};
  wire [15:0] enc_nib_acc = (acc & ~(`OHP_NIB_MASK << enc_sh)) |
                            ({12'h000, pe_index} << enc_sh);
  wire [7:0] enc_best = pe_any ? {idx[3:0], pe_index} : best;
  wire enc_hit = hit | pe_any;
  wire enc_bsel = first[0] ^ idx[4];
  wire [15:0] enc_byte_acc = enc_bsel ? {enc_best, acc[7:0]} : {acc[15:8], enc_best};
  wire group_end = (idx[3:0] == `OHP_GROUP_LAST);

  // ==========================================================
  // Segment merge into the destination word just read
  wire [15:0] seg_merged;

  genvar gb;
  generate
    for (gb = 0; gb < 2; gb = gb + 1) begin : g_half
      wire [2:0] pos = {idx[1:0], (gb == 1)};
      wire [2:0] rel = pos - {2'b00, half};
      wire in_rng = (pos >= {2'b00, half}) && (rel <= {1'b0, cnt_m1});
      wire [1:0] sdig = first + rel[1:0];
      wire [7:0] pat = seg(nib(src_word, sdig));
      assign seg_merged[gb*8+7:gb*8] = in_rng ? pat : mem_rdata_in[gb*8+7:gb*8];
    end
  endgenerate

  assign busy_out = (state != ST_IDLE);

  // ==========================================================
  // Sequencer; all writes happen only after every check has passed
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      op <= 2'h0;
      byte_mode <= 1'b0;
      first <= 2'h0;
      cnt_m1 <= 2'h0;
      half <= 1'b0;
      src_base <= 16'h0000;
      dst_base <= 16'h0000;
      idx <= 6'h00;
      last <= 6'h00;
      src_word <= 16'h0000;
      acc <= 16'h0000;
      best <= 8'h00;
      hit <= 1'b0;
      err <= 1'b0;
      done_out <= 1'b0;
      fault_flag_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            op <= op_in;
            byte_mode <= c_byte;
            first <= c_first[1:0];
            cnt_m1 <= c_cnt[1:0];
            half <= c_half[0];
            src_base <= src_addr_in;
            dst_base <= dst_addr_in;
            idx <= 6'h00;
            last <= span_m1;
            hit <= 1'b0;
            err <= 1'b0;
            if (!exec_cond_in) begin
              done_out <= 1'b1;
            end else if (start_err) begin
              fault_flag_out <= 1'b1;
              done_out <= 1'b1;
            end else if (op_in == `OHP_OP_ENCODE) begin
              state <= ST_RDST; // Result word read first; untouched digits keep
            end else begin
              state <= ST_RSRC;
            end
          end
        end
        ST_RSRC: begin
          mem_rd_out <= 1'b1;
          mem_addr_out <= (op == `OHP_OP_ENCODE) ? src_base + {10'h000, idx} : src_base;
          state <= ST_WSRC;
        end
        ST_WSRC: begin
          state <= ST_CSRC;
        end
        ST_CSRC: begin
          if (op == `OHP_OP_DECODE) begin
            src_word <= mem_rdata_in;
            state <= ST_WR;
          end else if (op == `OHP_OP_SEGMENT) begin
            src_word <= mem_rdata_in;
            state <= ST_RDST;
          end else if (!byte_mode) begin
            if (!pe_any) begin
              err <= 1'b1;
              state <= ST_DONE;
            end else begin
              acc <= enc_nib_acc;
              idx <= idx + 6'h01;
              state <= (idx == last) ? ST_WR : ST_RSRC;
            end
          end else begin
            best <= enc_best;
            hit <= enc_hit;
            if (group_end && !enc_hit) begin
              err <= 1'b1;
              state <= ST_DONE;
            end else begin
              if (group_end) begin
                acc <= enc_byte_acc;
                hit <= 1'b0;
              end
              idx <= idx + 6'h01;
              state <= (idx == last) ? ST_WR : ST_RSRC;
            end
          end
        end
        ST_RDST: begin
          mem_rd_out <= 1'b1;
          mem_addr_out <= (op == `OHP_OP_ENCODE) ? dst_base : dst_base + {10'h000, idx};
          state <= ST_WDST;
        end
        ST_WDST: begin
          state <= ST_CDST;
        end
        ST_CDST: begin
          if (op == `OHP_OP_ENCODE) begin
            acc <= mem_rdata_in;
            state <= ST_RSRC;
          end else begin
            acc <= seg_merged;
            state <= ST_WR;
          end
        end
        ST_WR: begin
          mem_wr_out <= 1'b1;
          if (op == `OHP_OP_DECODE) begin
            mem_addr_out <= dst_base + {10'h000, idx};
            mem_wdata_out <= dec_word;
            idx <= idx + 6'h01;
            state <= (idx == last) ? ST_DONE : ST_WR;
          end else if (op == `OHP_OP_ENCODE) begin
            mem_addr_out <= dst_base;
            mem_wdata_out <= acc;
            state <= ST_DONE;
          end else begin
            mem_addr_out <= dst_base + {10'h000, idx};
            mem_wdata_out <= acc;
            idx <= idx + 6'h01;
            state <= (idx == last) ? ST_DONE : ST_RDST;
          end
        end
        ST_DONE: begin
          fault_flag_out <= err;
          done_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** tb/ohp_conv_props.sv ***
`include "ohp_defs.vh"

// ==========================================================
// Port checker for the conversion datapath
module ohp_conv_props (
  input wire logic sys_clk_in, // Clock
  input wire logic resetn_in, // Reset, active low
  input wire logic start_in, // Request pulse
  input wire logic exec_cond_in, // Execution condition
  input wire logic [1:0] op_in, // Operation select
  input wire logic [15:0] ctrl_in, // Control word
  input wire logic [15:0] src_addr_in, // Source address
  input wire logic [15:0] dst_addr_in, // Destination address
  input wire logic busy_out, // Busy
  input wire logic done_out, // Done pulse
  input wire logic fault_flag_out, // Fault flag
  input wire logic mem_rd_out, // Read strobe
  input wire logic mem_wr_out, // Write strobe
  input wire logic [15:0] mem_addr_out, // Word address
  input wire logic [15:0] mem_wdata_out // Write data
);
  logic [1:0] op_q;
  logic [15:0] ctrl_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic wrote;
  wire start_ok = start_in && !busy_out;
  wire dec_nib = mem_wr_out && op_q == `OHP_OP_DECODE && ctrl_q[15:12] == 4'h0;

  // ==========================================================
  // Request capture; wrote tells whether the running op wrote memory
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_q <= 2'h0;
      ctrl_q <= 16'h0000;
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      wrote <= 1'b0;
    end else if (start_ok) begin
      op_q <= op_in;
      ctrl_q <= ctrl_in;
      src_q <= src_addr_in;
      dst_q <= dst_addr_in;
      wrote <= 1'b0;
    end else if (mem_wr_out) begin
      wrote <= 1'b1;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // ==========================================================
  // Condition-off request: quiet one-cycle finish
  sequence s_go_off;
    start_ok && !exec_cond_in;
  endsequence
  sequence s_quick_end;
    done_out && !busy_out && !mem_wr_out;
  endsequence

  a_off_quick_end: assert property (s_go_off |=> s_quick_end)
    else $error("condition off did not end quietly");
  a_off_flag_kept: assert property (s_go_off |=> $stable(fault_flag_out))
    else $error("condition off changed fault flag");
  a_bad_mode_fault: assert property (start_ok && exec_cond_in && op_in != `OHP_OP_SEGMENT
      && ctrl_in[15:12] > 4'h1 |=> done_out && fault_flag_out)
    else $error("undefined mode not faulted");
  a_bad_field_fault: assert property (start_ok && exec_cond_in && op_in == `OHP_OP_DECODE
      && ctrl_in[15:12] == 4'h0 && (ctrl_in[3:0] > 4'h3 || ctrl_in[7:4] > 4'h3)
      |=> done_out && fault_flag_out)
    else $error("out of range digit field not faulted");
  a_dec_word_onehot: assert property (dec_nib |-> $onehot(mem_wdata_out))
    else $error("digit decode word not one-hot");
  a_dec_word_span: assert property (dec_nib
      |-> 16'(mem_addr_out - dst_q) <= {12'h000, ctrl_q[7:4]})
    else $error("digit decode wrote outside its words");
  a_byte_onehot_zero: assert property (mem_wr_out && op_q == `OHP_OP_DECODE
      && ctrl_q[15:12] == 4'h1 |-> $onehot0(mem_wdata_out))
    else $error("byte decode word has several bits");
  a_dec_first_read: assert property ($rose(busy_out) && op_q == `OHP_OP_DECODE
      |=> mem_rd_out && mem_addr_out == src_q)
    else $error("decode did not start by reading source");
  a_enc_first_read: assert property ($rose(busy_out) && op_q == `OHP_OP_ENCODE
      |=> mem_rd_out && mem_addr_out == dst_q)
    else $error("encode did not start by reading result");
  a_fault_no_write: assert property (done_out && fault_flag_out |-> !wrote)
    else $error("faulted op wrote memory");
  a_run_bounded: assert property (start_ok |-> ##[1:400] done_out)
    else $error("op did not finish in time");
endmodule

bind ohp_conv ohp_conv_props u_props (.sys_clk_in, .resetn_in, .start_in, .exec_cond_in,
  .op_in, .ctrl_in, .src_addr_in, .dst_addr_in, .busy_out, .done_out, .fault_flag_out,
  .mem_rd_out, .mem_wr_out, .mem_addr_out, .mem_wdata_out);

// *** tb/test_onehot_priority_segment_conv.sv ***
`include "ohp_defs.vh"

module test_onehot_priority_segment_conv;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, resetn_in, start_in, exec_cond_in, indirect_in;
  logic [1:0] op_in;
  logic [15:0] ctrl_in, src_addr_in, dst_addr_in, area_lo_in, area_hi_in;
  logic [15:0] ptr_word_in, ptr_max_in, mem_rdata_in, mem_addr_out, mem_wdata_out;
  logic busy_out, done_out, fault_flag_out, mem_rd_out, mem_wr_out;
  logic [15:0] mem [0:1023];
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] seg_tab [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

  ohp_conv dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .start_in(start_in),
    .exec_cond_in(exec_cond_in), .op_in(op_in), .ctrl_in(ctrl_in),
    .src_addr_in(src_addr_in), .dst_addr_in(dst_addr_in), .area_lo_in(area_lo_in),
    .area_hi_in(area_hi_in), .indirect_in(indirect_in), .ptr_word_in(ptr_word_in),
    .ptr_max_in(ptr_max_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
    .done_out(done_out), .fault_flag_out(fault_flag_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));

  // ==========================================================
  // Clock, and a word store that answers a read by the next falling edge
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (mem_wr_out) mem[mem_addr_out[9:0]] <= mem_wdata_out;
  always @(negedge sys_clk_in) if (mem_rd_out) mem_rdata_in <= mem[mem_addr_out[9:0]];

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One request, then wait for done under a bound and judge the flag
  task automatic run(input logic [1:0] op, input logic [15:0] ctrl, input logic [15:0] src,
      input logic [15:0] dst, input logic cond, input logic flt);
    int n;
    op_in = op;
    ctrl_in = ctrl;
    src_addr_in = src;
    dst_addr_in = dst;
    exec_cond_in = cond;
    start_in = 1'b1;
    @(negedge sys_clk_in);
    start_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 400) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("done", 16'h0001, {15'h0, done_out});
    chk("fault_flag", {15'h0, flt}, {15'h0, fault_flag_out});
  endtask

  task automatic fill(input int a, input int n, input logic [15:0] v);
    for (int k = 0; k < n; k++) mem[a + k] = v;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_decode_digits;
    logic [3:0] dg [4] = '{4'h3, 4'ha, 4'h5, 4'hc};
    mem[10'h100] = 16'ha3c5;
    fill(10'h200, 5, 16'h5555);
    run(`OHP_OP_DECODE, 16'h0001, 16'h0100, 16'h0200, 1'b1, 1'b0);
    chk("dec one", 16'h1000, mem[10'h200]);
    chk("dec one kept", 16'h5555, mem[10'h201]);
    run(`OHP_OP_DECODE, 16'h0032, 16'h0100, 16'h0200, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) chk("dec wrap", 16'h0001 << dg[k], mem[10'h200 + k]);
    chk("dec wrap kept", 16'h5555, mem[10'h204]);
  endtask

  task automatic t_decode_bytes;
    fill(10'h200, 32, 16'hffff);
    run(`OHP_OP_DECODE, 16'h1011, 16'h0100, 16'h0200, 1'b1, 1'b0);
    for (int k = 0; k < 32; k++)
      chk("dec bytes", k == 10 ? 16'h0008 : k == 28 ? 16'h0020 : 16'h0000, mem[10'h200 + k]);
    run(`OHP_OP_DECODE, 16'h1000, 16'h0100, 16'h0200, 1'b1, 1'b0);
    chk("dec low byte", 16'h0020, mem[10'h20c]);
    chk("dec low other", 16'h0000, mem[10'h20a]);
  endtask

  task automatic t_faults;
    logic [15:0] bad [5] = '{16'h0004, 16'h0040, 16'h1002, 16'h1020, 16'h2000};
    fill(10'h200, 4, 16'h5a5a);
    for (int k = 0; k < 5; k++) run(`OHP_OP_DECODE, bad[k], 16'h0100, 16'h0200, 1'b1, 1'b1);
    run(2'h3, 16'h0001, 16'h0100, 16'h0200, 1'b1, 1'b1);
    chk("bad ctrl kept", 16'h5a5a, mem[10'h200]);
    run(`OHP_OP_DECODE, 16'h0020, 16'h0100, 16'h03fe, 1'b1, 1'b1);
    run(`OHP_OP_DECODE, 16'h0001, 16'h0100, 16'h0200, 1'b0, 1'b1);
    chk("off kept", 16'h5a5a, mem[10'h200]);
    run(`OHP_OP_ENCODE, 16'h0004, 16'h0100, 16'h0200, 1'b1, 1'b1);
    indirect_in = 1'b1;
    ptr_word_in = 16'h12a4;
    run(`OHP_OP_DECODE, 16'h0001, 16'h0100, 16'h0200, 1'b1, 1'b1);
    ptr_word_in = 16'h0100;
    run(`OHP_OP_DECODE, 16'h0001, 16'h0100, 16'h0200, 1'b1, 1'b1);
    ptr_word_in = 16'h0042;
    run(`OHP_OP_DECODE, 16'h0001, 16'h0100, 16'h0200, 1'b1, 1'b0);
    indirect_in = 1'b0;
  endtask

  task automatic t_encode;
    mem[10'h100] = 16'h0001;
    mem[10'h101] = 16'h8000;
    mem[10'h102] = 16'h0300;
    mem[10'h103] = 16'h0070;
    mem[10'h300] = 16'h1234;
    run(`OHP_OP_ENCODE, 16'h0032, 16'h0100, 16'h0300, 1'b1, 1'b0);
    chk("enc wrap", 16'hf069, mem[10'h300]);
    mem[10'h300] = 16'h1234;
    run(`OHP_OP_ENCODE, 16'h0001, 16'h0100, 16'h0300, 1'b1, 1'b0);
    chk("enc one", 16'h1204, mem[10'h300]);
    fill(10'h100, 32, 16'h0000);
    mem[10'h105] = 16'h0480;
    mem[10'h11f] = 16'h8000;
    mem[10'h300] = 16'hbeef;
    run(`OHP_OP_ENCODE, 16'h1000, 16'h0100, 16'h0300, 1'b1, 1'b0);
    chk("enc byte", 16'hbe5a, mem[10'h300]);
    run(`OHP_OP_ENCODE, 16'h1011, 16'h0100, 16'h0300, 1'b1, 1'b0);
    chk("enc two bytes", 16'h5aff, mem[10'h300]);
    run(`OHP_OP_ENCODE, 16'h0000, 16'h0100, 16'h0300, 1'b1, 1'b1);
    chk("enc zero kept", 16'h5aff, mem[10'h300]);
  endtask

  task automatic t_segment;
    for (int d = 0; d < 16; d++) begin
      mem[10'h100] = 16'(d);
      mem[10'h300] = 16'haaaa;
      run(`OHP_OP_SEGMENT, 16'h0000, 16'h0100, 16'h0300, 1'b1, 1'b0);
      chk("seg code", {8'haa, seg_tab[d]}, mem[10'h300]);
    end
    mem[10'h100] = 16'h8765;
    fill(10'h300, 4, 16'haaaa);
    run(`OHP_OP_SEGMENT, 16'h0133, 16'h0100, 16'h0300, 1'b1, 1'b0);
    chk("seg w0", 16'h7faa, mem[10'h300]);
    chk("seg w1", 16'h7d6d, mem[10'h301]);
    chk("seg w2", 16'haa27, mem[10'h302]);
    chk("seg w3", 16'haaaa, mem[10'h303]);
    run(`OHP_OP_SEGMENT, 16'h0200, 16'h0100, 16'h0300, 1'b1, 1'b1);
    run(`OHP_OP_SEGMENT, 16'h0130, 16'h0100, 16'h03ff, 1'b1, 1'b1);
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    miscompares++;
    report_and_stop;
  end

  initial begin
    resetn_in = 1'b0;
    start_in = 1'b0;
    exec_cond_in = 1'b0;
    op_in = 2'h0;
    ctrl_in = 16'h0000;
    src_addr_in = 16'h0000;
    dst_addr_in = 16'h0000;
    area_lo_in = 16'h0000;
    area_hi_in = 16'h03ff;
    indirect_in = 1'b0;
    ptr_word_in = 16'h0000;
    ptr_max_in = 16'h0099;
    mem_rdata_in = 16'h0000;
    repeat (2) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    t_decode_digits;
    t_decode_bytes;
    t_faults;
    t_encode;
    t_segment;
    report_and_stop;
  end
endmodule
